// ### core/pemx_pkg.sv
// Package for the port E address/GPIO pin multiplexer
package pemx_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned PEMX_PINS = 16;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_FUNC_SEL  = 5'h00;
    localparam logic [4:0] OFS_DIRECTION = 5'h04;
    localparam logic [4:0] OFS_DATA      = 5'h08;
    localparam logic [4:0] OFS_PIN_LEVEL = 5'h0c;
    localparam logic [4:0] OFS_STATUS    = 5'h10;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] FUNC_SEL_RST   = 16'h0000;
    localparam logic [15:0] DIRECTION_RST  = 16'h0000;
    localparam logic [15:0] DATA_RST       = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
    localparam int unsigned STAT_MODE_LSB  = 0;
    localparam int unsigned STAT_STBY_BIT  = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Code 2'b11 is illegal and is treated as single-chip
    typedef enum logic [1:0] {
        MODE_EXP_ROM_OFF = 2'b00,
        MODE_EXP_ROM_ON  = 2'b01,
        MODE_SINGLE_CHIP = 2'b10
    } pemx_mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pemx_avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } pemx_avl_rsp_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } pemx_pin_drv_t;

    typedef struct packed {
        logic [15:0]   func_sel;
        logic [15:0]   direction;
        logic [15:0]   gpio_data;
        logic [15:0]   pin_s1;
        logic [15:0]   pin_s2;
        logic          stby_s1;
        logic          stby_s2;
        logic [15:0]   addr_sel;
        pemx_pin_drv_t drv;
        pemx_avl_rsp_t rsp;
    } pemx_state_t;

    localparam pemx_state_t PEMX_STATE_RST = '{
        func_sel:  FUNC_SEL_RST,
        direction: DIRECTION_RST,
        gpio_data: DATA_RST,
        pin_s1:    16'h0000,
        pin_s2:    16'h0000,
        stby_s1:   1'b0,
        stby_s2:   1'b0,
        addr_sel:  16'h0000,
        drv:       '{out: 16'h0000, oe: 16'h0000},
        rsp:       '{readdata: UNMAPPED_READ, waitrequest: 1'b1}
    };

endpackage

// ### core/pemx_pin_mux.sv
// Port E pin multiplexer: address lines versus GPIO, with its registers
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/10ps

// Overview of operation
// - ROM-off expanded: all pins drive address
// - ROM-on expanded: register bits pick function
// - ROM-on: bit 0 GPIO, bit 1 address
// - Single-chip: all pins GPIO, register ignored
// - Bit n governs pin n, address n
// - Power-on reset, hardware standby clear register
// - Watchdog power-on reset keeps register
// - Software standby, sleep keep register
// - Function register is 16-bit read/write
// - GPIO pin: direction 1 output, 0 input
module pemx_pin_mux
    import pemx_pkg::*;
(
    // Clock and resets
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic          wdt_por,
    // Hardware standby request pin
    input  wire logic          hw_standby,
    // Operating mode from mode-selection logic
    input  wire pemx_mode_t    op_mode,
    // Address lines from the external bus controller
    input  wire logic [15:0]   addr_in,
    // Avalon-MM slave
    input  wire pemx_avl_req_t avl_req,
    output pemx_avl_rsp_t      avl_rsp,
    // Port E pads
    input  wire logic [15:0]   pin_in,
    output pemx_pin_drv_t      pin_drv
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pemx_state_t st_r;
    pemx_state_t st_nxt;

    logic [15:0] sel_w;
    logic [15:0] drv_out_w;
    logic [15:0] drv_oe_w;
    logic        wr_take;
    logic        wr_func_sel;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Per-pin function select
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PEMX_PINS; gi++) begin : g_pin
            always_comb begin
                unique case (op_mode)
                    MODE_EXP_ROM_OFF: sel_w[gi] = 1'b1;
                    MODE_EXP_ROM_ON:  sel_w[gi] = st_r.func_sel[gi];
                    MODE_SINGLE_CHIP: sel_w[gi] = 1'b0;
                    default:          sel_w[gi] = 1'b0;
                endcase
                drv_out_w[gi] = sel_w[gi] ? addr_in[gi] : st_r.gpio_data[gi];
                drv_oe_w[gi]  = sel_w[gi] | st_r.direction[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A write is carried out on the edge where waitrequest is seen low; read data is captured one edge earlier
    assign wr_take     = avl_req.write && !st_r.rsp.waitrequest;
    assign wr_func_sel = wr_take && (avl_req.address[4:2] == OFS_FUNC_SEL[4:2]);

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    always_comb begin
        rd_mux = UNMAPPED_READ;
        unique case (avl_req.address[4:2])
            OFS_FUNC_SEL[4:2]:  rd_mux = {16'h0000, st_r.func_sel};
            OFS_DIRECTION[4:2]: rd_mux = {16'h0000, st_r.direction};
            OFS_DATA[4:2]:      rd_mux = {16'h0000, st_r.gpio_data};
            OFS_PIN_LEVEL[4:2]: rd_mux = {16'h0000, st_r.pin_s2};
            OFS_STATUS[4:2]: begin
                rd_mux[STAT_MODE_LSB +: 2] = op_mode;
                rd_mux[STAT_STBY_BIT]      = st_r.stby_s2;
            end
            default:            rd_mux = UNMAPPED_READ;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt         = st_r;
        st_nxt.pin_s1  = pin_in;
        st_nxt.pin_s2  = st_r.pin_s1;
        st_nxt.stby_s1 = hw_standby;
        st_nxt.stby_s2 = st_r.stby_s1;

        // Handshake: one wait cycle, then one cycle with waitrequest low
        if ((avl_req.read || avl_req.write) && st_r.rsp.waitrequest) begin
            st_nxt.rsp.waitrequest = 1'b0;
            st_nxt.rsp.readdata    = avl_req.read ? rd_mux : UNMAPPED_READ;
        end else begin
            st_nxt.rsp.waitrequest = 1'b1;
        end

        // no sleep input, only writes and hardware standby change it
        if (wr_take) begin
            unique case (avl_req.address[4:2])
                OFS_FUNC_SEL[4:2]: st_nxt.func_sel =
                    merge16(st_r.func_sel, avl_req.writedata, avl_req.byteenable);
                OFS_DIRECTION[4:2]: st_nxt.direction =
                    merge16(st_r.direction, avl_req.writedata, avl_req.byteenable);
                OFS_DATA[4:2]: st_nxt.gpio_data =
                    merge16(st_r.gpio_data, avl_req.writedata, avl_req.byteenable);
                default: st_nxt.func_sel = st_r.func_sel;
            endcase
        end

        if (st_r.stby_s2) begin
            st_nxt.func_sel  = FUNC_SEL_RST;
            st_nxt.direction = DIRECTION_RST;
        end

        // watchdog reset only restarts the bus side
        if (wdt_por) begin
            st_nxt.rsp = PEMX_STATE_RST.rsp;
        end

        st_nxt.addr_sel = sel_w;
        st_nxt.drv.out  = drv_out_w;
        st_nxt.drv.oe   = drv_oe_w;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= PEMX_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avl_rsp = st_r.rsp;
    assign pin_drv = st_r.drv;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_rom_off_all_addr;
        (op_mode == MODE_EXP_ROM_OFF) |=>
            (pin_drv.oe == 16'hffff) && (pin_drv.out == $past(addr_in));
    endproperty
    a_rom_off_all_addr: assert property (p_rom_off_all_addr)
        else $error("ROM-off mode pin not driving address");

    property p_rom_on_oe;
        (op_mode == MODE_EXP_ROM_ON) |=>
            (pin_drv.oe == ($past(st_r.func_sel) | $past(st_r.direction)));
    endproperty
    a_rom_on_oe: assert property (p_rom_on_oe)
        else $error("ROM-on mode output enable wrong");

    property p_rom_on_out;
        (op_mode == MODE_EXP_ROM_ON) |=>
            (pin_drv.out == (($past(addr_in) & $past(st_r.func_sel)) |
                             ($past(st_r.gpio_data) & ~$past(st_r.func_sel))));
    endproperty
    a_rom_on_out: assert property (p_rom_on_out)
        else $error("ROM-on mode pin value wrong");

    property p_single_gpio;
        (op_mode == MODE_SINGLE_CHIP) |=>
            (pin_drv.out == $past(st_r.gpio_data)) && (st_r.addr_sel == 16'h0000);
    endproperty
    a_single_gpio: assert property (p_single_gpio)
        else $error("Single-chip pin not GPIO");

    property p_bit15_addr15;
        (op_mode == MODE_EXP_ROM_ON) && st_r.func_sel[15] |=>
            pin_drv.oe[15] && (pin_drv.out[15] == $past(addr_in[15]));
    endproperty
    a_bit15_addr15: assert property (p_bit15_addr15)
        else $error("Bit 15 does not select address 15");

    property p_stby_clears;
        st_r.stby_s2 |=> (st_r.func_sel == FUNC_SEL_RST) &&
                         (st_r.direction == DIRECTION_RST);
    endproperty
    a_stby_clears: assert property (p_stby_clears)
        else $error("Hardware standby did not clear registers");

    property p_wdt_keeps;
        wdt_por && !st_r.stby_s2 && !wr_func_sel |=> $stable(st_r.func_sel);
    endproperty
    a_wdt_keeps: assert property (p_wdt_keeps)
        else $error("Watchdog reset changed function register");

    property p_hold_idle;
        !st_r.stby_s2 && !wr_func_sel |=> $stable(st_r.func_sel);
    endproperty
    a_hold_idle: assert property (p_hold_idle)
        else $error("Function register changed without write");

    property p_rw_func_sel;
        wr_func_sel && (avl_req.byteenable[1:0] == 2'b11) && !st_r.stby_s2 |=>
            (st_r.func_sel == $past(avl_req.writedata[15:0]));
    endproperty
    a_rw_func_sel: assert property (p_rw_func_sel)
        else $error("Function register write lost");

    property p_read_func_sel;
        avl_req.read && st_r.rsp.waitrequest && !wdt_por &&
        (avl_req.address[4:2] == OFS_FUNC_SEL[4:2]) |=>
            !avl_rsp.waitrequest && (avl_rsp.readdata == {16'h0000, $past(st_r.func_sel)});
    endproperty
    a_read_func_sel: assert property (p_read_func_sel)
        else $error("Function register read wrong");

    property p_gpio_dir;
        (op_mode == MODE_SINGLE_CHIP) |=> (pin_drv.oe == $past(st_r.direction));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("GPIO output enable not from direction");

    property p_mode_follow;
        (op_mode == MODE_EXP_ROM_OFF) ##1 (op_mode == MODE_SINGLE_CHIP) |=>
            (pin_drv.oe == $past(st_r.direction)) && $past(st_r.addr_sel == 16'hffff);
    endproperty
    a_mode_follow: assert property (p_mode_follow)
        else $error("Pin function did not follow mode change");

    property p_ack_one_cycle;
        !avl_rsp.waitrequest |=> avl_rsp.waitrequest;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("Waitrequest low longer than one cycle");

    property p_por_clears;
        disable iff (1'b0)
        reset |=> (st_r.func_sel == FUNC_SEL_RST) && (st_r.direction == DIRECTION_RST) &&
                  (pin_drv.oe == 16'h0000) && avl_rsp.waitrequest;
    endproperty
    a_por_clears: assert property (p_por_clears)
        else $error("Power-on reset did not clear registers");

    property p_stby_beats_write;
        st_r.stby_s2 && wr_func_sel |=> (st_r.func_sel == FUNC_SEL_RST);
    endproperty
    a_stby_beats_write: assert property (p_stby_beats_write)
        else $error("Write survived hardware standby");

    property p_wdt_keeps_port;
        wdt_por && !st_r.stby_s2 && !wr_take |=>
            $stable(st_r.direction) && $stable(st_r.gpio_data);
    endproperty
    a_wdt_keeps_port: assert property (p_wdt_keeps_port)
        else $error("Watchdog reset changed port registers");

    property p_illegal_mode_gpio;
        (op_mode == 2'h3) |=>
            (st_r.addr_sel == 16'h0000) && (pin_drv.out == $past(st_r.gpio_data));
    endproperty
    a_illegal_mode_gpio: assert property (p_illegal_mode_gpio)
        else $error("Unused mode code drove an address line");

    property p_rom_on_gpio_dir;
        (op_mode == MODE_EXP_ROM_ON) |=>
            ((pin_drv.oe & ~$past(st_r.func_sel)) ==
             ($past(st_r.direction) & ~$past(st_r.func_sel)));
    endproperty
    a_rom_on_gpio_dir: assert property (p_rom_on_gpio_dir)
        else $error("ROM-on GPIO pin direction wrong");

endmodule // pemx_pin_mux

// ### tb/pemx_pin_mux_test.sv
// Self-checking bench for the port E pin multiplexer
`timescale 1ns/10ps
module pemx_pin_mux_test
    import pemx_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic           core_clk   = 1'b0;
    logic           reset      = 1'b1;
    logic           wdt_por    = 1'b0;
    logic           hw_standby = 1'b0;
    pemx_mode_t     op_mode    = MODE_SINGLE_CHIP;
    logic [15:0]    addr_in    = 16'h0000;
    logic [15:0]    pin_in     = 16'h0000;
    pemx_avl_req_t  avl_req    = '0;
    pemx_avl_rsp_t  avl_rsp;
    pemx_pin_drv_t  pin_drv;
    int             error_cnt   = 0;
    int             check_count = 0;
    int             cyc         = 0;

    localparam logic [15:0] FSV  = 16'h8001;
    localparam logic [15:0] DIRV = 16'h0f0f;
    localparam logic [15:0] DATV = 16'h3355;
    localparam logic [15:0] ADA  = 16'hc3a6;
    localparam logic [15:0] ADB  = 16'h3c59;

    pemx_pin_mux pemx_pin_mux_i (
        .core_clk   (core_clk),
        .reset      (reset),
        .wdt_por    (wdt_por),
        .hw_standby (hw_standby),
        .op_mode    (op_mode),
        .addr_in    (addr_in),
        .avl_req    (avl_req),
        .avl_rsp    (avl_rsp),
        .pin_in     (pin_in),
        .pin_drv    (pin_drv)
    );

    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Verdict, hang guard and comparisons
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_pins(input string what, input logic [1:0] m, input logic [15:0] fs,
                            input logic [15:0] dir, input logic [15:0] dat,
                            input logic [15:0] adr);
        pemx_pin_drv_t exp;
        exp = exp_pins(m, fs, dir, dat, adr);
        check_count++;
        if (pin_drv !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, pin_drv);
        end
    endtask

    function automatic pemx_pin_drv_t exp_pins(input logic [1:0] m, input logic [15:0] fs,
                                               input logic [15:0] dir, input logic [15:0] dat,
                                               input logic [15:0] adr);
        logic [15:0] sel;
        sel = (m == 2'b00) ? 16'hffff : ((m == 2'b01) ? fs : 16'h0000);
        exp_pins.out = (sel & adr) | (~sel & dat);
        exp_pins.oe  = sel | dir;
    endfunction

    // ------------------------------------------------------------
    // Avalon-MM master
    // ------------------------------------------------------------
    // Starts on a fresh edge so a release and a new request never share a step
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        avl_req <= '{read: !wr, write: wr, address: adr, byteenable: be, writedata: wd};
        @(posedge core_clk);
        while (avl_rsp.waitrequest !== 1'b0) @(posedge core_clk);
        rd = avl_rsp.readdata;
        avl_req <= '0;
    endtask

    task automatic rd_chk(input string what, input logic [4:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, adr, 4'h3, 32'h0000_0000, rd);
        chk_word(what, exp, rd);
    endtask

    task automatic settle();
        repeat (3) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        pin_in <= 16'h5aa5;
        rd_chk("func_sel reset", OFS_FUNC_SEL, 32'h0000_0000);
        rd_chk("direction reset", OFS_DIRECTION, 32'h0000_0000);
        bus(1'b1, OFS_FUNC_SEL, 4'h3, 32'hffff_a5c3, rd);
        rd_chk("func_sel rw", OFS_FUNC_SEL, 32'h0000_a5c3);
        bus(1'b1, OFS_FUNC_SEL, 4'h1, 32'h0000_00ff, rd);
        rd_chk("func_sel low lane", OFS_FUNC_SEL, 32'h0000_a5ff);
        bus(1'b1, OFS_FUNC_SEL, 4'h2, 32'h0000_12ee, rd);
        rd_chk("func_sel high lane", OFS_FUNC_SEL, 32'h0000_12ff);
        bus(1'b1, 5'h14, 4'h3, 32'h0000_1234, rd);
        rd_chk("unmapped", 5'h14, UNMAPPED_READ);
        rd_chk("pin level", OFS_PIN_LEVEL, 32'h0000_5aa5);
    endtask

    task automatic t_modes();
        logic [31:0] rd;
        addr_in <= ADA;
        bus(1'b1, OFS_DIRECTION, 4'h3, {16'h0000, DIRV}, rd);
        bus(1'b1, OFS_DATA, 4'h3, {16'h0000, DATV}, rd);
        bus(1'b1, OFS_FUNC_SEL, 4'h3, {16'h0000, FSV}, rd);
        rd_chk("direction rw", OFS_DIRECTION, {16'h0000, DIRV});
        rd_chk("data rw", OFS_DATA, {16'h0000, DATV});
        for (int m = 0; m < 4; m++) begin
            op_mode <= pemx_mode_t'(m[1:0]);
            settle();
            chk_pins("pins mode", m[1:0], FSV, DIRV, DATV, ADA);
            if (m == 1) begin
                chk_word("pin 15 level", {31'h0, ADA[15]}, {31'h0, pin_drv.out[15]});
            end
            if (m == 2) begin
                chk_word("gpio enables", {16'h0000, DIRV}, {16'h0000, pin_drv.oe});
            end
            rd_chk("status mode", OFS_STATUS, {30'h0, m[1:0]});
        end
        // Address mode straight into single-chip
        op_mode <= MODE_EXP_ROM_OFF;
        @(posedge core_clk);
        op_mode <= MODE_SINGLE_CHIP;
        settle();
        chk_pins("pins rom off to single", 2'h2, FSV, DIRV, DATV, ADA);
        op_mode <= MODE_EXP_ROM_ON;
        addr_in <= ADB;
        settle();
        chk_pins("pins new addr", 2'h1, FSV, DIRV, DATV, ADB);
    endtask

    task automatic t_wdt();
        wdt_por <= 1'b1;
        repeat (2) @(posedge core_clk);
        wdt_por <= 1'b0;
        rd_chk("func_sel after wdt", OFS_FUNC_SEL, {16'h0000, FSV});
        rd_chk("direction after wdt", OFS_DIRECTION, {16'h0000, DIRV});
        chk_pins("pins after wdt", 2'h1, FSV, DIRV, DATV, ADB);
    endtask

    task automatic t_standby();
        logic [31:0] rd;
        hw_standby <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd_chk("status in stby", OFS_STATUS, 32'h0000_0005);
        // A write while standby is seen must be lost
        bus(1'b1, OFS_FUNC_SEL, 4'h3, 32'h0000_00ff, rd);
        hw_standby <= 1'b0;
        settle();
        rd_chk("func_sel after stby", OFS_FUNC_SEL, 32'h0000_0000);
        rd_chk("direction after stby", OFS_DIRECTION, 32'h0000_0000);
        rd_chk("data after stby", OFS_DATA, {16'h0000, DATV});
        chk_pins("pins after stby", 2'h1, 16'h0000, 16'h0000, DATV, ADB);
    endtask

    task automatic t_por();
        logic [31:0] rd;
        bus(1'b1, OFS_FUNC_SEL, 4'h3, 32'h0000_ffff, rd);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd_chk("func_sel after por", OFS_FUNC_SEL, 32'h0000_0000);
        settle();
        chk_pins("pins after por", 2'h1, 16'h0000, 16'h0000, 16'h0000, ADB);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        t_regs();
        t_modes();
        t_wdt();
        t_standby();
        t_por();
        complete_run();
    end

endmodule // pemx_pin_mux_test
